// File: src/lhp_consts.svh
`ifndef LHP_CONSTS_SVH
`define LHP_CONSTS_SVH

// register offsets from the board port base
`define LHP_DATA_OFS      8'h02
`define LHP_STAT_OFS      8'h03

// status field positions
`define LHP_ST_AVAIL_BIT  0
`define LHP_ST_TAKEN_BIT  1

// reset value and default port base
`define LHP_DATA_RST      8'h00
`define LHP_BASE_DEFAULT  8'h10

// bus write strobe width, clock period in ns
`define LHP_CLK_NS        10
`define LHP_WSTB_MIN_NS   150
`define LHP_WSTB_MAX_NS   1000
`define LHP_WSTB_MIN_CYC  ((`LHP_WSTB_MIN_NS + `LHP_CLK_NS - 1) / `LHP_CLK_NS)
`define LHP_WSTB_MAX_CYC  (`LHP_WSTB_MAX_NS / `LHP_CLK_NS)

`endif

// File: src/lhp_pkg.sv
package lhp_pkg;

    // strap settings of the port
    typedef struct packed {
        logic       input_strobe_polarity_select;
        logic       output_enable_polarity_select;
        logic       transparent_select;
        logic [1:0] attention_mode_jumper;
    } lhp_cfg_t;

    // peripheral-side input pins
    typedef struct packed {
        logic       strobe;
        logic       output_enable;
        logic [7:0] data;
    } lhp_periph_t;

    typedef enum logic [3:0] {
        LHP_ATT_LVL_HI   = 4'b0001,
        LHP_ATT_LVL_LO   = 4'b0010,
        LHP_ATT_PULS_POS = 4'b0100,
        LHP_ATT_PULS_NEG = 4'b1000
    } lhp_att_mode_t;

endpackage

// File: src/lhp_port.sv
`timescale 1ns/1ns
`include "lhp_consts.svh"
// How it works
// RULE1: data register at base plus two
// RULE2: status register at base plus three
// RULE3: status bit0 input available, bit1 taken
// RULE4: input strobe captures data, sets available flag
// RULE5: edge latch: polarity picks rising or falling
// RULE6: transparent latch flows during pulse, holds after
// RULE7: open strobe, polarity on: always live data
// RULE8: output enable drives data, clears attention, taken
// RULE9: enable polarity: on active low, off high
// RULE10: strobed mode: peripheral holds enable asserted
// RULE11: attention has four selectable behaviours
// RULE12: level mode: write raises attention active
// RULE13: level mode: enable returns attention idle
// RULE14: attention flag state readable via status
// RULE15: pulse mode: attention follows write strobe width
// RULE16: input interrupt, no initialization needed
// RULE17: data read clears available and interrupt
// RULE18: reset clears available, attention idles; code holds attention low in reset, idle level once straps settle
module lhp_port
    import lhp_pkg::*;
#(
    parameter logic [7:0] PORT_BASE = `LHP_BASE_DEFAULT
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // host bus pins
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_read_strobe,
    input  wire logic        bus_write_strobe,
    output logic      [7:0]  bus_rdata,
    output logic             bus_rdata_valid,
    // straps
    input  wire lhp_cfg_t    cfg,
    // peripheral pins
    input  wire lhp_periph_t periph,
    output logic      [7:0]  out_data,
    output logic             out_data_oe,
    output logic             attention,
    output logic             in_irq
);

    // two-flop synchronisers for every pin
    logic [7:0]  addr_s1,  addr_s;
    logic [7:0]  wdata_s1, wdata_s;
    logic        rd_s1,    rd_s;
    logic        wr_s1,    wr_s;
    logic        rd_d,     wr_d;
    lhp_cfg_t    cfg_s1,   cfg_s;
    lhp_periph_t per_s1,   per_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_s1  <= 8'h00;
            addr_s   <= 8'h00;
            wdata_s1 <= 8'h00;
            wdata_s  <= 8'h00;
            rd_s1    <= 1'b0;
            rd_s     <= 1'b0;
            wr_s1    <= 1'b0;
            wr_s     <= 1'b0;
            rd_d     <= 1'b0;
            wr_d     <= 1'b0;
            cfg_s1   <= '0;
            cfg_s    <= '0;
            per_s1   <= '0;
            per_s    <= '0;
        end else begin
            addr_s1  <= bus_addr;
            addr_s   <= addr_s1;
            wdata_s1 <= bus_wdata;
            wdata_s  <= wdata_s1;
            rd_s1    <= bus_read_strobe;
            rd_s     <= rd_s1;
            wr_s1    <= bus_write_strobe;
            wr_s     <= wr_s1;
            rd_d     <= rd_s;
            wr_d     <= wr_s;
            cfg_s1   <= cfg;
            cfg_s    <= cfg_s1;
            per_s1   <= periph;
            per_s    <= per_s1;
        end
    end

    // address decode; strobes act on their leading edge
    logic sel_data;
    logic sel_stat;
    logic wr_data;
    logic rd_data;
    logic rd_stat;

    assign sel_data = (addr_s == PORT_BASE + `LHP_DATA_OFS); // RULE1
    assign sel_stat = (addr_s == PORT_BASE + `LHP_STAT_OFS); // RULE2
    assign wr_data  = wr_s & ~wr_d & sel_data;
    assign rd_data  = rd_s & ~rd_d & sel_data;
    assign rd_stat  = rd_s & ~rd_d & sel_stat;

    // input channel; an open strobe pin floats high through its pull-up
    logic strb_act;
    logic strb_act_d;
    logic cap;
    logic [7:0] in_reg;
    logic avail_reg;

    assign strb_act = (per_s.strobe == cfg_s.input_strobe_polarity_select);     // RULE5
    assign cap      = cfg_s.transparent_select ? strb_act                       // RULE6
                                               : (strb_act & ~strb_act_d);      // RULE5

    // reset as if already active: synced pins and straps come out of
    // reset at zero, which would otherwise read as a false strobe edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strb_act_d <= 1'b1;
        end else begin
            strb_act_d <= strb_act;
        end
    end

    // transparent mode reloads every cycle while active, so an open
    // strobe with polarity on keeps the register live
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_reg <= `LHP_DATA_RST;
        end else if (cap) begin
            in_reg <= per_s.data; // RULE4 RULE7
        end
    end

    // set wins over the read clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avail_reg <= 1'b0; // RULE18
        end else if (cap) begin
            avail_reg <= 1'b1; // RULE4
        end else if (rd_data) begin
            avail_reg <= 1'b0; // RULE17
        end
    end

    // output channel
    logic       oe_act;
    logic [7:0] out_reg;
    logic       att_flag_reg;
    logic       att_flag_next;

    assign oe_act = per_s.output_enable ^ cfg_s.output_enable_polarity_select; // RULE9

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_reg <= `LHP_DATA_RST;
        end else if (wr_data) begin
            out_reg <= wdata_s; // RULE1
        end
    end

    // enable holds the flag clear like a hardware clear input, so in
    // strobed operation a write never leaves attention stuck active
    always_comb begin
        att_flag_next = att_flag_reg;
        if (oe_act) begin
            att_flag_next = 1'b0; // RULE8 RULE13
        end else if (wr_data) begin
            att_flag_next = 1'b1; // RULE12
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            att_flag_reg <= 1'b0;
        end else begin
            att_flag_reg <= att_flag_next;
        end
    end

    // drivers stay off until the peripheral enables them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_data    <= `LHP_DATA_RST;
            out_data_oe <= 1'b0;
        end else begin
            out_data    <= out_reg;
            out_data_oe <= oe_act; // RULE8 RULE10
        end
    end

    // attention output
    lhp_att_mode_t att_mode;
    logic          wstb_pulse;
    logic          att_next;

    assign wstb_pulse = wr_s & sel_data; // RULE15

    always_comb begin
        case (cfg_s.attention_mode_jumper) // RULE11
            2'b00:   att_mode = LHP_ATT_LVL_HI;
            2'b01:   att_mode = LHP_ATT_LVL_LO;
            2'b10:   att_mode = LHP_ATT_PULS_POS;
            default: att_mode = LHP_ATT_PULS_NEG;
        endcase
    end

    always_comb begin
        case (att_mode)
            LHP_ATT_LVL_HI:   att_next = att_flag_next;  // RULE12
            LHP_ATT_LVL_LO:   att_next = ~att_flag_next; // RULE12
            LHP_ATT_PULS_POS: att_next = wstb_pulse;     // RULE15
            LHP_ATT_PULS_NEG: att_next = ~wstb_pulse;    // RULE15
            default:          att_next = 1'b0;
        endcase
    end

    // straps settle a few cycles after reset; idle level follows them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            attention <= 1'b0; // RULE18
        end else begin
            attention <= att_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_irq <= 1'b0;
        end else begin
            in_irq <= cap | (avail_reg & ~rd_data); // RULE16 RULE17
        end
    end

    // read path; unmapped addresses return zero with no valid
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata       <= 8'h00;
            bus_rdata_valid <= 1'b0;
        end else begin
            bus_rdata_valid <= rd_data | rd_stat;
            if (rd_data) begin
                bus_rdata <= in_reg; // RULE1
            end else if (rd_stat) begin
                bus_rdata <= 8'h00; // RULE3
                bus_rdata[`LHP_ST_AVAIL_BIT] <= avail_reg; // RULE3
                bus_rdata[`LHP_ST_TAKEN_BIT] <= ~att_flag_reg; // RULE14
            end else begin
                bus_rdata <= 8'h00;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_data_write: assert property ( // RULE1
        wr_data |=> out_reg == $past(wdata_s) ##1 out_data == $past(out_reg))
        else $error("data write not loaded into output register");

    chk_status_read: assert property ( // RULE3
        rd_stat |=> bus_rdata_valid && bus_rdata[7:2] == 6'h00
            && bus_rdata[`LHP_ST_AVAIL_BIT] == $past(avail_reg)
            && bus_rdata[`LHP_ST_TAKEN_BIT] == !$past(att_flag_reg))
        else $error("status read content wrong");

    chk_edge_capture: assert property ( // RULE5
        (!cfg_s.transparent_select && strb_act && !strb_act_d)
            |=> in_reg == $past(per_s.data) && avail_reg)
        else $error("strobe edge did not capture input");

    chk_edge_hold: assert property ( // RULE5
        (!cfg_s.transparent_select && !(strb_act && !strb_act_d))
            |=> $stable(in_reg))
        else $error("edge latch changed without strobe edge");

    chk_transp_flow: assert property ( // RULE6
        (cfg_s.transparent_select && strb_act) |=> in_reg == $past(per_s.data))
        else $error("transparent latch not flowing");

    chk_oe_drive: assert property ( // RULE8
        oe_act |=> out_data_oe && !att_flag_reg)
        else $error("enable did not drive data or clear attention");

    chk_oe_tristate: assert property ( // RULE9
        !oe_act |=> !out_data_oe)
        else $error("drivers on without enable");

    chk_att_level_set: assert property ( // RULE12
        (att_mode == LHP_ATT_LVL_HI && wr_data && !oe_act)
            |=> attention ##1 (attention || $past(oe_act)))
        else $error("level attention not raised by write");

    chk_att_level_idle: assert property ( // RULE13
        (att_mode == LHP_ATT_LVL_LO && oe_act) |=> attention)
        else $error("attention not back at idle level");

    chk_att_pulse: assert property ( // RULE15
        (att_mode == LHP_ATT_PULS_NEG && wr_s && sel_data) |=> !attention)
        else $error("negative attention pulse missing");

    chk_read_clear: assert property ( // RULE17
        (rd_data && !cap) |=> !avail_reg && !in_irq)
        else $error("data read did not clear available");

    chk_data_read: assert property ( // RULE1
        rd_data |=> bus_rdata_valid && bus_rdata == $past(in_reg))
        else $error("data read returned wrong byte");

    chk_unmapped_read: assert property ( // RULE2
        (rd_s && !rd_d && !sel_data && !sel_stat) |=> !bus_rdata_valid)
        else $error("unmapped read answered");

    chk_rdata_idle: assert property ( // RULE3
        (!rd_data && !rd_stat) |=> bus_rdata == 8'h00 && !bus_rdata_valid)
        else $error("read bus not idle without read");

    chk_avail_set: assert property ( // RULE4
        cap |=> avail_reg && in_irq)
        else $error("capture did not set available");

    chk_transp_hold: assert property ( // RULE6
        (cfg_s.transparent_select && !strb_act) |=> $stable(in_reg))
        else $error("transparent latch changed after pulse");

    chk_out_data_path: assert property ( // RULE8
        oe_act |=> out_data_oe && out_data == $past(out_reg))
        else $error("enabled drivers not showing output register");

    chk_att_low_set: assert property ( // RULE12
        (att_mode == LHP_ATT_LVL_LO && wr_data && !oe_act) |=> !attention)
        else $error("low level attention not raised by write");

    chk_att_high_idle: assert property ( // RULE13
        (att_mode == LHP_ATT_LVL_HI && oe_act) |=> !attention)
        else $error("high level attention not back at idle");

    chk_att_pulse_pos: assert property ( // RULE15
        (att_mode == LHP_ATT_PULS_POS) |=> attention == $past(wstb_pulse))
        else $error("positive attention pulse wrong");

    chk_irq_tracks: assert property ( // RULE16
        in_irq == avail_reg)
        else $error("interrupt request differs from available flag");

endmodule // lhp_port

// File: tb/lhp_periph_model.sv
`timescale 1ns/1ns
module lhp_periph_model
    import lhp_pkg::*;
(
    // clock and straps
    input  wire logic     clk,
    input  wire lhp_cfg_t cfg,
    // pins toward the port
    output lhp_periph_t   periph
);
    initial begin
        periph = '{strobe: 1'b1, output_enable: 1'b0, data: 8'hff};
    end
    // released data lines float to the on-board pull-ups; the strobe goes to its inactive level
    task automatic idle();
        @(negedge clk);
        periph.strobe = ~cfg.input_strobe_polarity_select;
        periph.data   = 8'hff;
    endtask
    task automatic open_strobe(input logic [7:0] d);
        @(negedge clk);
        periph.strobe = 1'b1;
        periph.data   = d;
    endtask
    // data held past the strobe end so a latch closing late still sees it
    task automatic strobe_byte(input logic [7:0] d);
        @(negedge clk);
        periph.data = d;
        @(negedge clk);
        periph.strobe = cfg.input_strobe_polarity_select;
        repeat (3) @(negedge clk);
        periph.strobe = ~cfg.input_strobe_polarity_select;
        repeat (2) @(negedge clk);
        periph.data = 8'hff;
    endtask
    task automatic set_enable(input logic on);
        @(negedge clk);
        periph.output_enable = on ^ cfg.output_enable_polarity_select;
    endtask
endmodule // lhp_periph_model

// File: tb/lhp_port_tb_top.sv
`timescale 1ns/1ns
`include "lhp_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module lhp_port_tb_top
    import lhp_pkg::*;
;
    localparam logic [7:0] DATA_A = `LHP_BASE_DEFAULT + `LHP_DATA_OFS;
    localparam logic [7:0] STAT_A = `LHP_BASE_DEFAULT + `LHP_STAT_OFS;
    logic        clk;
    logic        resetn;
    logic [7:0]  bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_read_strobe;
    logic        bus_write_strobe;
    logic [7:0]  bus_rdata;
    logic        bus_rdata_valid;
    lhp_cfg_t    cfg;
    lhp_periph_t periph;
    logic [7:0]  out_data;
    logic        out_data_oe;
    logic        attention;
    logic        in_irq;
    int          num_errors;
    int          checked;
    int          cycles;
    logic [7:0]  rd;
    logic        got;

    lhp_port #(.PORT_BASE(`LHP_BASE_DEFAULT)) lhp_port_inst (
        .clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_read_strobe(bus_read_strobe), .bus_write_strobe(bus_write_strobe),
        .bus_rdata(bus_rdata), .bus_rdata_valid(bus_rdata_valid), .cfg(cfg),
        .periph(periph), .out_data(out_data), .out_data_oe(out_data_oe),
        .attention(attention), .in_irq(in_irq));
    lhp_periph_model lhp_periph_model_inst (.clk(clk), .cfg(cfg), .periph(periph));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // a hung handshake ends the run here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    function automatic lhp_cfg_t mk(logic p, logic q, logic t, logic [1:0] m);
        return '{input_strobe_polarity_select: p, output_enable_polarity_select: q,
                 transparent_select: t, attention_mode_jumper: m};
    endfunction
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input int w);
        @(negedge clk);
        bus_addr  = a;
        bus_wdata = d;
        repeat (3) @(negedge clk);
        bus_write_strobe = 1'b1;
        repeat (w) @(negedge clk);
        bus_write_strobe = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // strobe stays up until the valid pulse is seen or the bound runs out
    task automatic bus_read(input logic [7:0] a);
        int n;
        @(negedge clk);
        bus_addr = a;
        got = 1'b0;
        repeat (3) @(negedge clk);
        bus_read_strobe = 1'b1;
        for (n = 0; n < 8 && got !== 1'b1; n++) begin
            @(negedge clk);
            if (bus_rdata_valid === 1'b1) begin
                got = 1'b1;
                rd  = bus_rdata;
            end
        end
        bus_read_strobe = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // straps settle, then a read drops any capture caused by the change
    task automatic set_cfg(input lhp_cfg_t c);
        @(negedge clk);
        cfg = c;
        lhp_periph_model_inst.idle();
        repeat (6) @(negedge clk);
        bus_read(DATA_A);
    endtask

    task automatic test_reset();
        `CHK(attention, 1'b1)
        `CHK(in_irq, 1'b0)
        bus_read(STAT_A);
        `CHK(rd[1:0], 2'b10)
        bus_read(8'h15);
        `CHK(got, 1'b0)
        $display("test reset done");
    endtask
    task automatic test_edge();
        for (int p = 0; p < 2; p++) begin
            set_cfg(mk(p[0], 1'b0, 1'b0, 2'b00));
            lhp_periph_model_inst.strobe_byte(8'h5a ^ p[7:0]);
            repeat (4) @(negedge clk);
            `CHK(in_irq, 1'b1)
            bus_read(STAT_A);
            `CHK(rd[1:0], 2'b11)
            bus_read(DATA_A);
            `CHK(rd, 8'h5a ^ p[7:0])
            `CHK(in_irq, 1'b0)
            bus_read(STAT_A);
            `CHK(rd[0], 1'b0)
        end
        $display("test edge done");
    endtask
    task automatic test_transparent();
        set_cfg(mk(1'b1, 1'b0, 1'b1, 2'b00));
        lhp_periph_model_inst.open_strobe(8'h3c);
        repeat (5) @(negedge clk);
        bus_read(DATA_A);
        `CHK(rd, 8'h3c)
        lhp_periph_model_inst.open_strobe(8'hc3);
        repeat (5) @(negedge clk);
        bus_read(DATA_A);
        `CHK(rd, 8'hc3)
        set_cfg(mk(1'b0, 1'b0, 1'b1, 2'b00));
        lhp_periph_model_inst.strobe_byte(8'h96);
        repeat (4) @(negedge clk);
        bus_read(DATA_A);
        `CHK(rd, 8'h96)
        $display("test transparent done");
    endtask
    task automatic test_handshake();
        for (int m = 0; m < 2; m++) begin
            set_cfg(mk(1'b0, m[0], 1'b0, m[1:0]));
            lhp_periph_model_inst.set_enable(1'b0);
            bus_write(DATA_A, 8'ha0 | m[7:0], 3);
            `CHK(out_data_oe, 1'b0)
            `CHK(attention, ~m[0])
            bus_read(STAT_A);
            `CHK(rd[1:0], 2'b00)
            lhp_periph_model_inst.set_enable(1'b1);
            repeat (5) @(negedge clk);
            `CHK(out_data_oe, 1'b1)
            `CHK(out_data, 8'ha0 | m[7:0])
            `CHK(attention, m[0])
            bus_read(STAT_A);
            `CHK(rd[1], 1'b1)
            lhp_periph_model_inst.set_enable(1'b0);
        end
        $display("test handshake done");
    endtask
    task automatic test_pulse();
        int n;
        for (int m = 2; m < 4; m++) begin
            set_cfg(mk(1'b0, 1'b0, 1'b0, m[1:0]));
            lhp_periph_model_inst.set_enable(1'b1);
            fork
                bus_write(DATA_A, 8'h40 | m[7:0], 15 + 10 * m);
                begin
                    n = 0;
                    repeat (27 + 10 * m) begin
                        @(negedge clk);
                        if (attention === ~m[0]) n++;
                    end
                end
            join
            `CHK(n, 15 + 10 * m)
            `CHK(attention, m[0])
            bus_write(8'h15, 8'h77, 3);
            `CHK(out_data, 8'h40 | m[7:0])
        end
        $display("test pulse done");
    endtask
    // reset in mid-run with flags set; zeroed synchronisers must not fake a strobe
    task automatic test_midreset();
        set_cfg(mk(1'b1, 1'b0, 1'b0, 2'b00));
        lhp_periph_model_inst.set_enable(1'b0);
        bus_write(DATA_A, 8'h81, 3);
        lhp_periph_model_inst.strobe_byte(8'h24);
        repeat (4) @(negedge clk);
        `CHK(attention, 1'b1)
        `CHK(in_irq, 1'b1)
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        `CHK(attention, 1'b0)
        `CHK(in_irq, 1'b0)
        `CHK(out_data, 8'h00)
        bus_read(STAT_A);
        `CHK(rd[1:0], 2'b10)
        $display("test midreset done");
    endtask

    task automatic conclude();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_read_strobe = 1'b0;
        bus_write_strobe = 1'b0;
        cfg = mk(1'b0, 1'b0, 1'b0, 2'b01);
        num_errors = 0;
        checked = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        test_reset();
        test_edge();
        test_transparent();
        test_handshake();
        test_pulse();
        test_midreset();
        conclude();
    end
endmodule // lhp_port_tb_top
